// *** logic/mfs_pkg.sv ***
// constants and types shared by the macsec format selector
package mfs_pkg;

  // protection format chosen by software
  typedef enum logic [1:0] {MFS_STD, MFS_BYP1, MFS_BYP2, MFS_MPLS} mfs_mode_t;

  localparam int unsigned NUM_SA    = 16;
  localparam int unsigned SA_W      = 4;
  localparam int unsigned FLD_W     = 11;
  localparam int unsigned LEN_W     = 5;

  // classification field select bits (carrier addresses reuse the address bits)
  localparam logic [10:0] M_DA      = 11'h001;
  localparam logic [10:0] M_SA      = 11'h002;
  localparam logic [10:0] M_ETYPE   = 11'h004;
  localparam logic [10:0] M_TPID1   = 11'h008;
  localparam logic [10:0] M_VID1    = 11'h010;
  localparam logic [10:0] M_TPID2   = 11'h020;
  localparam logic [10:0] M_VID2    = 11'h040;
  localparam logic [10:0] M_SECTAG  = 11'h080;
  localparam logic [10:0] M_METYPE  = 11'h100;
  localparam logic [10:0] M_LABEL1  = 11'h200;
  localparam logic [10:0] M_LABEL2  = 11'h400;

  // per-sa select value after reset: every field allowed
  localparam logic [10:0] SA_MASK_RST = 11'h7FF;

  // header byte counts that stay in clear
  localparam logic [4:0] ADDR_LEN   = 5'h0C;
  localparam logic [4:0] TAG_LEN    = 5'h04;
  localparam logic [4:0] METYPE_LEN = 5'h02;
  localparam logic [4:0] LABEL_LEN  = 5'h04;

  // one classified frame descriptor
  typedef struct packed {
    logic [10:0] fields;
    logic [4:0]  clear_len;
    logic        key_256;
    logic        ptp;
  } mfs_res_t;

endpackage

// *** logic/mfs_str_if.sv ***
// valid/ready descriptor carrier between selector and its buffer
`timescale 1ns/1ps
interface mfs_str_if;
  logic              valid;
  logic              ready;
  mfs_pkg::mfs_res_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** logic/mfs_buf2.sv ***
// two-entry descriptor buffer, all outputs registered
`timescale 1ns/1ps
module mfs_buf2 (
  input  wire logic clk,
  input  wire logic reset_n,
  mfs_str_if.snk    up,
  mfs_str_if.src    dn
);

  logic              head_v_ff;
  logic              skid_v_ff;
  mfs_pkg::mfs_res_t head_ff;
  mfs_pkg::mfs_res_t skid_ff;
  logic              push;
  logic              pop;
  logic              up_rdy_ff;

  // ready comes from its own flop so the top output has no gate in front of it
  assign push     = up.valid & ~skid_v_ff;
  assign pop      = head_v_ff & dn.ready;
  assign up.ready = up_rdy_ff;
  assign dn.valid = head_v_ff;
  assign dn.data  = head_ff;

  ////////////////////////////////////////////////////////////////
  // head slot: refilled from skid first to keep frame order
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      head_v_ff <= 1'b0;
      head_ff   <= '0;
    end else if (!head_v_ff || pop) begin
      if (skid_v_ff) begin
        head_ff   <= skid_ff;
        head_v_ff <= 1'b1;
      end else begin
        head_ff   <= up.data;
        head_v_ff <= push;
      end
    end
  end

  // skid slot catches a word while the receiver stalls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skid_v_ff <= 1'b0;
      skid_ff   <= '0;
    end else if (pop) begin
      skid_v_ff <= 1'b0;
    end else if (push && head_v_ff) begin
      skid_ff   <= up.data;
      skid_v_ff <= 1'b1;
    end
  end

  // input ready mirrors an empty skid slot, updated on the same terms
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_rdy_ff <= 1'b1;
    end else if (pop) begin
      up_rdy_ff <= 1'b1;
    end else if (push && head_v_ff) begin
      up_rdy_ff <= 1'b0;
    end
  end

endmodule

// *** logic/mfs_format_sel.sv ***
// macsec frame format and classification field selector
`timescale 1ns/1ps
module mfs_format_sel (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire mfs_pkg::mfs_mode_t  mode,
  input  wire logic                key_256,
  input  wire logic                sa_cfg_we,
  input  wire logic [3:0]          sa_cfg_idx,
  input  wire logic [10:0]         sa_cfg_mask,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic                in_rx,
  input  wire logic [3:0]          in_sa_idx,
  input  wire logic [1:0]          in_tag_cnt,
  input  wire logic                in_mpls,
  input  wire logic [1:0]          in_label_cnt,
  input  wire logic                in_ptp,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [10:0]              out_fields,
  output logic [4:0]               out_clear_len,
  output logic                     out_key_256,
  output logic                     out_ptp,
  output logic                     pause_req
);

  logic [10:0]       sa_mask_ff [mfs_pkg::NUM_SA];
  logic [10:0]       allowed;
  logic [4:0]        clear_len;
  logic              pause_ff;
  logic              two_lbl;
  mfs_str_if         up_if ();
  mfs_str_if         dn_if ();

  ////////////////////////////////////////////////////////////////
  // per-association field select table
  for (genvar i = 0; i < mfs_pkg::NUM_SA; i++) begin : g_sa
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sa_mask_ff[i] <= mfs_pkg::SA_MASK_RST;
      end else if (sa_cfg_we && sa_cfg_idx == 4'(i)) begin
        sa_mask_ff[i] <= sa_cfg_mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // fields visible to the classifier and length of the clear header
  assign two_lbl = (in_label_cnt == 2'h2);

  always_comb begin
    allowed   = mfs_pkg::M_DA | mfs_pkg::M_SA;
    clear_len = mfs_pkg::ADDR_LEN;
    if (mode == mfs_pkg::MFS_MPLS && in_mpls) begin
      // carrier header is never encrypted, both directions see it
      allowed   = allowed | mfs_pkg::M_METYPE | mfs_pkg::M_LABEL1;
      clear_len = mfs_pkg::ADDR_LEN + mfs_pkg::METYPE_LEN + mfs_pkg::LABEL_LEN;
      if (two_lbl) begin
        allowed   = allowed | mfs_pkg::M_LABEL2;
        clear_len = clear_len + mfs_pkg::LABEL_LEN;
      end
      if (in_rx) begin
        allowed = allowed | mfs_pkg::M_SECTAG;
      end
    end else if (!in_rx) begin
      // transmit side still sees the plaintext frame
      allowed = allowed | mfs_pkg::M_ETYPE;
      if (in_tag_cnt != 2'h0) begin
        allowed = allowed | mfs_pkg::M_TPID1 | mfs_pkg::M_VID1;
      end
      if (in_tag_cnt == 2'h2) begin
        allowed = allowed | mfs_pkg::M_TPID2 | mfs_pkg::M_VID2;
      end
    end else begin
      // receive side: only what sits ahead of the security tag
      allowed = allowed | mfs_pkg::M_SECTAG;
      if (mode != mfs_pkg::MFS_STD && mode != mfs_pkg::MFS_MPLS && in_tag_cnt != 2'h0) begin
        allowed = allowed | mfs_pkg::M_TPID1 | mfs_pkg::M_VID1;
      end
      if (mode == mfs_pkg::MFS_BYP2 && in_tag_cnt == 2'h2) begin
        allowed = allowed | mfs_pkg::M_TPID2 | mfs_pkg::M_VID2;
      end
    end
    // clear tag bytes, same for both directions of the transform
    if (mode == mfs_pkg::MFS_BYP1 && in_tag_cnt != 2'h0) begin
      clear_len = mfs_pkg::ADDR_LEN + mfs_pkg::TAG_LEN;
    end else if (mode == mfs_pkg::MFS_BYP2 && in_tag_cnt != 2'h0) begin
      // both tags stay ahead of the security tag when two are present
      if (in_tag_cnt == 2'h2) begin
        clear_len = mfs_pkg::ADDR_LEN + mfs_pkg::TAG_LEN + mfs_pkg::TAG_LEN;
      end else begin
        clear_len = mfs_pkg::ADDR_LEN + mfs_pkg::TAG_LEN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // descriptor into the buffer; a timing frame takes the normal path
  assign up_if.valid          = in_valid;
  assign up_if.data.fields    = allowed & sa_mask_ff[in_sa_idx];
  assign up_if.data.clear_len = clear_len;
  assign up_if.data.key_256   = key_256;
  assign up_if.data.ptp       = in_ptp;
  assign dn_if.ready          = out_ready;

  mfs_buf2 u_buf (
    .clk     (clk),
    .reset_n (reset_n),
    .up      (up_if),
    .dn      (dn_if)
  );

  // buffer full means expansion is backing up: ask the system mac to pause
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pause_ff <= 1'b0;
    end else begin
      pause_ff <= ~up_if.ready;
    end
  end

  // outputs all come from buffer or pause flops
  assign in_ready      = up_if.ready;
  assign out_valid     = dn_if.valid;
  assign out_fields    = dn_if.data.fields;
  assign out_clear_len = dn_if.data.clear_len;
  assign out_key_256   = dn_if.data.key_256;
  assign out_ptp       = dn_if.data.ptp;
  assign pause_req     = pause_ff;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_push;
    in_valid && in_ready;
  endsequence
  sequence s_stall;
    out_valid && !out_ready;
  endsequence

  property p_sa_mask;
    s_push |-> (up_if.data.fields & ~sa_mask_ff[in_sa_idx]) == 11'h000;
  endproperty
  a_sa_mask: assert property (p_sa_mask) else $error("field outside sa mask");

  property p_std_rx;
    s_push and (mode == mfs_pkg::MFS_STD && in_rx) |->
      (up_if.data.fields & ~(mfs_pkg::M_DA | mfs_pkg::M_SA | mfs_pkg::M_SECTAG)) == 11'h000;
  endproperty
  a_std_rx: assert property (p_std_rx) else $error("standard rx uses a tag field");

  property p_tx_untag;
    s_push and (!in_rx && in_tag_cnt == 2'h0 && !(mode == mfs_pkg::MFS_MPLS && in_mpls)) |->
      (allowed == (mfs_pkg::M_DA | mfs_pkg::M_SA | mfs_pkg::M_ETYPE));
  endproperty
  a_tx_untag: assert property (p_tx_untag) else $error("untagged tx field set wrong");

  property p_tx_dual;
    s_push and (!in_rx && in_tag_cnt == 2'h2 && !(mode == mfs_pkg::MFS_MPLS && in_mpls)) |->
      allowed == 11'h07F;
  endproperty
  a_tx_dual: assert property (p_tx_dual) else $error("dual tagged tx field set wrong");

  property p_byp1_single;
    s_push and (mode == mfs_pkg::MFS_BYP1 && in_rx && in_tag_cnt == 2'h1) |->
      clear_len == 5'h10 && allowed == 11'h09B;
  endproperty
  a_byp1_single: assert property (p_byp1_single) else $error("single bypass rx fields wrong");

  property p_byp1_dual;
    s_push and (mode == mfs_pkg::MFS_BYP1 && in_rx && in_tag_cnt == 2'h2) |->
      clear_len == 5'h10 && allowed[6:3] == 4'h3;
  endproperty
  a_byp1_dual: assert property (p_byp1_dual) else $error("single bypass exposed inner tag");

  // transmit side of single bypass: inner tag is matchable but still protected
  property p_byp1_tx;
    s_push and (mode == mfs_pkg::MFS_BYP1 && !in_rx && in_tag_cnt == 2'h2) |->
      clear_len == 5'h10 && allowed == 11'h07F;
  endproperty
  a_byp1_tx: assert property (p_byp1_tx) else $error("single bypass tx clear header wrong");

  property p_byp2;
    s_push and (mode == mfs_pkg::MFS_BYP2 && in_tag_cnt == 2'h2) |-> clear_len == 5'h14 && allowed[6:3] == 4'hF;
  endproperty
  a_byp2: assert property (p_byp2) else $error("dual bypass clear header wrong");

  property p_mpls;
    s_push and (mode == mfs_pkg::MFS_MPLS && in_mpls) |->
      clear_len == (two_lbl ? 5'h16 : 5'h12) && allowed[8] && allowed[7] == in_rx;
  endproperty
  a_mpls: assert property (p_mpls) else $error("mpls clear header wrong");

  // an empty buffer shows the pushed key size on the very next cycle
  property p_key;
    s_push and !out_valid |=>
      out_valid && out_key_256 == $past(key_256);
  endproperty
  a_key: assert property (p_key) else $error("key size lost");

  property p_pause;
    s_stall and !in_ready |=> pause_req;
  endproperty
  a_pause: assert property (p_pause) else $error("full buffer without pause");

  // a full buffer that drains one word takes input again on the cycle after the drain
  property p_drain;
    (s_stall and !in_ready) ##1 (out_valid && out_ready) |=> in_ready;
  endproperty
  a_drain: assert property (p_drain) else $error("buffer stays full after drain");

  property p_hold;
    s_stall |=> out_valid && $stable(out_fields) && $stable(out_clear_len) && $stable(out_ptp);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled frame changed");

  property p_ptp_len;
    s_push and in_ptp |-> clear_len <= 5'h16 && clear_len >= 5'h0C;
  endproperty
  a_ptp_len: assert property (p_ptp_len) else $error("timing frame left unprotected");

endmodule

// *** sim/mfs_sink.sv ***
// far-side receiver model for the descriptor stream
`timescale 1ns/1ps
module mfs_sink (
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  stall,
  input  wire logic  valid,
  output logic       ready,
  output logic [7:0] n_taken
);
  logic       rdy_ff;
  logic [7:0] cnt_ff;

  // ready is registered: a stall shows one edge late, as a real mac would
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_ff <= 1'b0;
    end else begin
      rdy_ff <= !stall;
    end
  end

  // one whole descriptor taken per handshake
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 8'h00;
    end else if (valid && rdy_ff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign ready   = rdy_ff;
  assign n_taken = cnt_ff;
endmodule

// *** sim/mfs_format_sel_tb.sv ***
// self-checking bench for the format selector
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module mfs_format_sel_tb;
  typedef struct packed {
    mfs_pkg::mfs_mode_t m;
    logic               rx;
    logic [1:0]         tg;
    logic               mp;
    logic [1:0]         lb;
    logic [10:0]        f;
    logic [4:0]         c;
  } mfs_row_t;

  logic clk = 1'b0, reset_n = 1'b0, key_256 = 1'b0, sa_cfg_we = 1'b0, in_valid = 1'b0;
  logic in_rx = 1'b0, in_mpls = 1'b0, in_ptp = 1'b0, stall = 1'b0;
  logic [3:0] sa_cfg_idx = 4'h0, in_sa_idx = 4'h0;
  logic [10:0] sa_cfg_mask = 11'h000;
  logic [1:0] in_tag_cnt = 2'h0, in_label_cnt = 2'h0;
  mfs_pkg::mfs_mode_t mode = mfs_pkg::MFS_STD;
  logic in_ready, out_valid, out_ready, out_key_256, out_ptp, pause_req;
  logic [10:0] out_fields;
  logic [4:0] out_clear_len;
  logic [7:0] n_taken;
  int n_fail = 0, check_count = 0;

  // ordinary cases: format inputs beside the expected fields and clear length
  mfs_row_t rows [12] = '{
    '{mfs_pkg::MFS_STD, 0, 0, 0, 1, 11'h007, 5'h0C}, '{mfs_pkg::MFS_STD, 0, 1, 0, 1, 11'h01F, 5'h0C},
    '{mfs_pkg::MFS_STD, 0, 2, 0, 1, 11'h07F, 5'h0C}, '{mfs_pkg::MFS_STD, 1, 2, 0, 1, 11'h083, 5'h0C},
    '{mfs_pkg::MFS_BYP1, 1, 1, 0, 1, 11'h09B, 5'h10}, '{mfs_pkg::MFS_BYP1, 1, 2, 0, 1, 11'h09B, 5'h10},
    '{mfs_pkg::MFS_BYP1, 0, 2, 0, 1, 11'h07F, 5'h10}, '{mfs_pkg::MFS_BYP2, 1, 2, 0, 1, 11'h0FB, 5'h14},
    '{mfs_pkg::MFS_BYP2, 1, 1, 0, 1, 11'h09B, 5'h10}, '{mfs_pkg::MFS_MPLS, 0, 0, 1, 1, 11'h303, 5'h12},
    '{mfs_pkg::MFS_MPLS, 1, 0, 1, 2, 11'h783, 5'h16}, '{mfs_pkg::MFS_MPLS, 1, 0, 0, 1, 11'h083, 5'h0C}};

  initial begin
    forever #12.5 clk = ~clk;
  end

  mfs_format_sel mfs_format_sel_i (.clk(clk), .reset_n(reset_n), .mode(mode), .key_256(key_256),
    .sa_cfg_we(sa_cfg_we), .sa_cfg_idx(sa_cfg_idx), .sa_cfg_mask(sa_cfg_mask), .in_valid(in_valid),
    .in_ready(in_ready), .in_rx(in_rx), .in_sa_idx(in_sa_idx), .in_tag_cnt(in_tag_cnt), .in_mpls(in_mpls),
    .in_label_cnt(in_label_cnt), .in_ptp(in_ptp), .out_valid(out_valid), .out_ready(out_ready),
    .out_fields(out_fields), .out_clear_len(out_clear_len), .out_key_256(out_key_256), .out_ptp(out_ptp),
    .pause_req(pause_req));

  mfs_sink mfs_sink_i (.clk(clk), .reset_n(reset_n), .stall(stall), .valid(out_valid), .ready(out_ready),
    .n_taken(n_taken));

  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // called at a falling edge; holds the offer until the edge that takes it, returns at the next falling edge
  task automatic push(input mfs_row_t r, input logic k, input logic p, input logic [3:0] s);
    int i;
    mode         = r.m;
    in_rx        = r.rx;
    in_tag_cnt   = r.tg;
    in_mpls      = r.mp;
    in_label_cnt = r.lb;
    key_256      = k;
    in_ptp       = p;
    in_sa_idx    = s;
    in_valid     = 1'b1;
    for (i = 0; i < 20 && in_ready !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    @(posedge clk);
    @(negedge clk);
  endtask

  // called at a falling edge; compares while the word stands, then lets its handshake edge pass
  task automatic get(input logic [10:0] f, input logic [4:0] c, input logic k, input logic p);
    int i;
    for (i = 0; i < 20 && !(out_valid === 1'b1 && out_ready === 1'b1); i++) begin
      @(negedge clk);
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    `CHK(out_fields, f)
    `CHK(out_clear_len, c)
    `CHK(out_key_256, k)
    `CHK(out_ptp, p)
    @(negedge clk);
  endtask

  // withdraw the offer at the falling edge a push returned on
  task automatic idle();
    in_valid = 1'b0;
  endtask

  initial begin
    // reset held two cycles, outputs idle meanwhile
    repeat (2) @(negedge clk);
    `CHK({in_ready, out_valid, pause_req}, 3'h4)
    reset_n = 1'b1;
    // table of ordinary cases, key size and timing flag varied by row
    for (int i = 0; i < 12; i++) begin
      push(rows[i], i[0], i[1], 4'(i));
      idle();
      get(rows[i].f, rows[i].c, i[0], i[1]);
    end
    // per-association mask narrows only its own association
    sa_cfg_we   = 1'b1;
    sa_cfg_idx  = 4'h5;
    sa_cfg_mask = 11'h001;
    @(negedge clk);
    sa_cfg_we = 1'b0;
    push(rows[0], 1'b0, 1'b0, 4'h5);
    idle();
    get(11'h001, 5'h0C, 1'b0, 1'b0);
    push(rows[0], 1'b0, 1'b0, 4'h4);
    idle();
    get(11'h007, 5'h0C, 1'b0, 1'b0);
    // receiver stalls: two words buffered, input ready drops, pause raised
    stall = 1'b1;
    push(rows[0], 1'b1, 1'b0, 4'h0);
    push(rows[4], 1'b0, 1'b1, 4'h0);
    idle();
    `CHK(in_ready, 1'b0)
    @(negedge clk);
    `CHK(pause_req, 1'b1)
    stall = 1'b0;
    get(rows[0].f, rows[0].c, 1'b1, 1'b0);
    get(rows[4].f, rows[4].c, 1'b0, 1'b1);
    @(negedge clk);
    `CHK(pause_req, 1'b0)
    `CHK(n_taken, 8'h10)
    // reset in mid-run drops the held word and restores the masks
    stall = 1'b1;
    push(rows[0], 1'b0, 1'b0, 4'h5);
    idle();
    reset_n = 1'b0;
    #1;
    `CHK({in_ready, out_valid, pause_req}, 3'h4)
    stall = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    push(rows[0], 1'b0, 1'b0, 4'h5);
    idle();
    get(11'h007, 5'h0C, 1'b0, 1'b0);
    // the word held across reset is gone: only the later one reached the receiver
    `CHK(n_taken, 8'h01)
    print_verdict();
  end
endmodule
